// >>> common/ccg_cfg.svh
// field positions, reset values and timing counts of the clock block
`ifndef CCG_CFG_SVH
`define CCG_CFG_SVH
`define CCG_CCR_RST 8'h04
`define CCG_OSC_RST 8'h00
`define CCG_DIV_LSB 0
`define CCG_DIV_MSB 2
`define CCG_DIV_MAX 3'h4
`define CCG_BYPASS_BIT 0
`define CCG_STAB_EXP 17
`define CCG_STAB_CYCLES (1 << `CCG_STAB_EXP)
`define CCG_STRETCH_CYCLES 2'h2
`define CCG_DLY_BASE 6'h20
`define CCG_PRE_W 5
`endif

// >>> common/ccg_pkg.sv
// types shared by the clock generator control files
package ccg_pkg;
  typedef enum logic [4:0] {
    CCG_ST_RESET = 5'b0_0001,
    CCG_ST_STAB = 5'b0_0010,
    CCG_ST_RUN = 5'b0_0100,
    CCG_ST_HALT = 5'b0_1000,
    CCG_ST_STOP = 5'b1_0000
  } ccg_state_t;

  typedef struct packed {
    logic osc_run;
    logic cpu_run;
    logic halted;
    logic stopped;
    logic switch_pending;
  } ccg_stat_t;

  // true when the prescaler sits on the last count of a 2**code period
  function automatic logic ccg_at_boundary(input logic [4:0] cnt,
                                           input logic [2:0] code);
    logic [4:0] mask;
    mask = 5'((6'h01 << code) - 6'h01);
    return (cnt & mask) == mask;
  endfunction
endpackage

// >>> design/ccg_div.sv
// prescaler that divides the main system clock into peripheral ticks
`timescale 1ns/10ps
`include "ccg_cfg.svh"
module ccg_div
  import ccg_pkg::*;
#(
  parameter int PRE_W = 8
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // main clock enable
  input wire logic fxx_en,
  // divided outputs
  output logic [PRE_W-1:0] pre_cnt,
  output logic [PRE_W-1:0] periph_tick
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] cnt_d;

  // count only on main clock ticks, so peripherals stop with it
  always_comb
  begin
    cnt_d = cnt_q;
    if (fxx_en)
      cnt_d = cnt_q + PRE_W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign pre_cnt = cnt_q;

  // tick i fires once every 2**(i+1) main clocks
  for (genvar i = 0; i < PRE_W; i++)
  begin : g_tick
    assign periph_tick[i] = fxx_en && (&cnt_q[i:0]);
  end
endmodule

// >>> design/ccg_top.sv
// cpu clock generator control: scaler, cpu rate select, standby, switchover
`timescale 1ns/10ps
`include "ccg_cfg.svh"
module ccg_top
  import ccg_pkg::*;
#(
  parameter int STAB_CYCLES = `CCG_STAB_CYCLES,
  parameter int PRE_W = 8
)(
  // oscillator clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register writes from the cpu core
  input wire logic ccr_wr,
  input wire logic osc_wr,
  input wire logic [7:0] wr_data,
  // standby control
  input wire logic stop_req,
  input wire logic halt_req,
  input wire logic wake,
  // register readback
  output logic [7:0] cpu_clock_ctrl_reg,
  output logic [7:0] osc_mode_select_reg,
  // clock enables
  output logic fxx_en,
  output logic cpu_tick,
  output logic [PRE_W-1:0] periph_tick,
  // status
  output ccg_stat_t status
);
  localparam int SW = $clog2(STAB_CYCLES) + 1;
  localparam logic [SW-1:0] STAB_LAST = SW'(STAB_CYCLES - 1);

  ccg_state_t state_q, state_d;
  logic [SW-1:0] stab_q, stab_d;
  logic [2:0] ccr_q, ccr_d;
  logic osc_q, osc_d;
  logic [2:0] act_q, act_d;
  logic pend_q, pend_d;
  logic [5:0] dly_q, dly_d;
  logic [1:0] str_q, str_d;
  logic half_q, half_d;
  logic osc_run;
  logic [PRE_W-1:0] pre_cnt;
  logic div_ok;

  // codes above the slowest rate are prohibited and get dropped
  assign div_ok = wr_data[`CCG_DIV_MSB:`CCG_DIV_LSB] <= `CCG_DIV_MAX;

  // standby and stabilisation sequencing
  always_comb
  begin
    state_d = state_q;
    stab_d = stab_q;
    case (state_q)
      CCG_ST_RESET:
      begin
        state_d = CCG_ST_STAB; // oscillator restarts at release
        stab_d = '0;
      end
      CCG_ST_STAB:
      begin
        stab_d = stab_q + SW'(1);
        if (stab_q == STAB_LAST)
          state_d = CCG_ST_RUN;
      end
      CCG_ST_RUN:
      begin
        if (stop_req)
          state_d = CCG_ST_STOP; // stop wins over halt
        else if (halt_req)
          state_d = CCG_ST_HALT;
      end
      CCG_ST_HALT:
        if (wake)
          state_d = CCG_ST_RUN;
      CCG_ST_STOP:
      begin
        stab_d = '0;
        if (wake)
          state_d = CCG_ST_STAB; // oscillator needs to settle again
      end
      default:
        state_d = CCG_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= CCG_ST_RESET; // oscillator held off
      stab_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      stab_q <= stab_d;
    end
  end

  assign osc_run = !(state_q inside {CCG_ST_RESET, CCG_ST_STOP});

  // main clock: direct or halved, frozen while a mode write settles
  always_comb
  begin
    str_d = str_q;
    half_d = half_q;
    osc_d = osc_q;
    if (osc_wr)
    begin
      osc_d = wr_data[`CCG_BYPASS_BIT];
      str_d = `CCG_STRETCH_CYCLES; // any write, same data too
    end
    else if (str_q != 2'h0)
      str_d = str_q - 2'h1;
    else if (osc_run)
      half_d = !half_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      str_q <= 2'h0;
      half_q <= 1'b0;
      osc_q <= 1'(`CCG_OSC_RST >> `CCG_BYPASS_BIT);
    end
    else
    begin
      str_q <= str_d;
      half_q <= half_d;
      osc_q <= osc_d;
    end
  end

  // bypass feeds every oscillator period, else every second one
  assign fxx_en = osc_run && !osc_wr && str_q == 2'h0 &&
                  (osc_q || half_q);

  ccg_div #(
    .PRE_W(PRE_W)
  ) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fxx_en(fxx_en),
    .pre_cnt(pre_cnt),
    .periph_tick(periph_tick)
  );

  // cpu rate: fxx divided by 2**act_q, halted cpu sees no ticks
  assign cpu_tick = state_q == CCG_ST_RUN && fxx_en &&
                    ccg_at_boundary(pre_cnt[`CCG_PRE_W-1:0], act_q);

  // divide register and delayed switchover
  always_comb
  begin
    ccr_d = ccr_q;
    act_d = act_q;
    pend_d = pend_q;
    dly_d = dly_q;
    if (pend_q && cpu_tick)
    begin
      dly_d = dly_q - 6'h1; // old clock ticks, two per instruction
      if (dly_q == 6'h1)
      begin
        act_d = ccr_q; // lands on an old clock edge
        pend_d = 1'b0;
      end
    end
    if (ccr_wr && div_ok)
    begin
      ccr_d = wr_data[`CCG_DIV_MSB:`CCG_DIV_LSB];
      if (!pend_q || (cpu_tick && dly_q == 6'h1))
      begin
        pend_d = 1'b1;
        dly_d = `CCG_DLY_BASE >> ccr_q; // 16 >> old code instrs
      end
    end
  end

  // prohibited codes are dropped so the cpu never loses its clock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ccr_q <= 3'(`CCG_CCR_RST >> `CCG_DIV_LSB);
      act_q <= 3'(`CCG_CCR_RST >> `CCG_DIV_LSB);
      pend_q <= 1'b0;
      dly_q <= 6'h0;
    end
    else
    begin
      ccr_q <= ccr_d;
      act_q <= act_d;
      pend_q <= pend_d;
      dly_q <= dly_d;
    end
  end

  // readback shows the written code, not the one still in force
  assign cpu_clock_ctrl_reg = {5'h0_0, ccr_q};
  assign osc_mode_select_reg = {7'h00, osc_q};

  assign status.osc_run = osc_run;
  assign status.cpu_run = state_q == CCG_ST_RUN;
  assign status.halted = state_q == CCG_ST_HALT;
  assign status.stopped = state_q == CCG_ST_STOP;
  assign status.switch_pending = pend_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_reset_vals;
    @(posedge clk_sys) disable iff (1'b0)
      !rst_n |=> cpu_clock_ctrl_reg == 8'h04 && osc_mode_select_reg == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");

  property p_osc_off;
    @(posedge clk_sys) disable iff (1'b0) !rst_n |=> !osc_run && !fxx_en;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator runs in reset");

  property p_code_legal;
    act_q <= 3'h4 && cpu_clock_ctrl_reg[7:3] == 5'h00;
  endproperty
  a_code_legal: assert property (p_code_legal)
    else $error("illegal divide code in force");

  property p_switch_edge;
    $changed(act_q) |-> $past(cpu_tick);
  endproperty
  a_switch_edge: assert property (p_switch_edge)
    else $error("switch off clock boundary");

  property p_readback;
    ccr_wr && div_ok |=> cpu_clock_ctrl_reg[2:0] == $past(wr_data[2:0]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback not new code");

  property p_stab_exit;
    state_q == CCG_ST_STAB && $past(state_q) != CCG_ST_STAB
      |-> !cpu_tick throughout (state_q == CCG_ST_STAB)[*8];
  endproperty
  a_stab_exit: assert property (p_stab_exit)
    else $error("cpu ticks during stabilisation");

  property p_run_entry;
    state_q == CCG_ST_RUN && $past(state_q) == CCG_ST_STAB
      |-> $past(stab_q) == STAB_LAST;
  endproperty
  a_run_entry: assert property (p_run_entry)
    else $error("stabilisation wait wrong length");

  property p_stretch;
    osc_wr |-> !fxx_en ##1 !fxx_en [*2];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("mode write did not stretch");

  property p_periph_stop;
    periph_tick != '0 |-> fxx_en && osc_run;
  endproperty
  a_periph_stop: assert property (p_periph_stop)
    else $error("peripheral tick without main clock");

  property p_bypass;
    osc_q && osc_run && str_q == 2'h0 && !osc_wr |-> fxx_en;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass not at oscillator rate");

  property p_delay;
    pend_q && cpu_tick && dly_q == 6'h1 && !ccr_wr |=> !pend_q;
  endproperty
  a_delay: assert property (p_delay)
    else $error("switchover overran");

  property p_halt;
    state_q == CCG_ST_HALT |-> !cpu_tick && osc_run;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt mode wrong");

  c_switch: cover property (pend_q ##1 !pend_q);
  c_stop_wake: cover property (state_q == CCG_ST_STOP ##1 wake);
  c_fast: cover property (act_q == 3'h0 && osc_q && cpu_tick);
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the cpu clock generator control block
`timescale 1ns/10ps
module tb_top
  import ccg_pkg::*;
;
  localparam int STAB = 16;
  localparam int PW = 8;
  logic clk_sys = 1'b0;
  logic rst_n, ccr_wr, osc_wr, stop_req, halt_req, wake;
  logic [7:0] wr_data, ccr_rb, osc_rb;
  logic fxx_en, cpu_tick;
  logic [PW-1:0] periph_tick;
  ccg_stat_t status;
  int mismatches = 0;
  int checks = 0;
  // reference model: current divide code and bypass bit
  int code_m, mode_m, n, k;
  logic [31:0] lfsr_q = 32'h9127_f566;

  always #10 clk_sys = ~clk_sys;

  ccg_top #(.STAB_CYCLES(STAB), .PRE_W(PW)) ccg_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ccr_wr(ccr_wr), .osc_wr(osc_wr),
    .wr_data(wr_data), .stop_req(stop_req), .halt_req(halt_req),
    .wake(wake), .cpu_clock_ctrl_reg(ccr_rb), .osc_mode_select_reg(osc_rb),
    .fxx_en(fxx_en), .cpu_tick(cpu_tick), .periph_tick(periph_tick),
    .status(status));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // inputs change and outputs are sampled at the falling edge
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // cycles until the next cpu tick, bounded so a dead clock cannot hang
  task automatic next_tick(output int t);
    t = 0;
    do
    begin
      cyc(1);
      t++;
    end
    while (cpu_tick !== 1'b1 && t < 2000);
  endtask

  // cycles until the cpu leaves the settling wait, bounded the same way
  task automatic wait_run(output int t);
    t = 0;
    do
    begin
      cyc(1);
      t++;
    end
    while (status.cpu_run !== 1'b1 && t < 2000);
  endtask

  // spacing of cpu ticks from the model's code and bypass bit
  task automatic rate();
    int t;
    next_tick(t);
    next_tick(t);
    check(t, (2 - mode_m) << code_m);
  endtask

  // write a divide code; upper bits random, they must be ignored
  task automatic set_code(input int c);
    int old, t, m;
    old = code_m;
    lfsr_q = lfsr_next(lfsr_q);
    // a tick in the write cycle would blur the delay count
    if (mode_m == 0)
      repeat (4) if (cpu_tick === 1'b1) cyc(1);
    wr_data = {lfsr_q[7:3], 3'(c)};
    ccr_wr = 1'b1;
    cyc(1);
    ccr_wr = 1'b0;
    if (c <= 4)
      code_m = c;
    check(ccr_rb, 32'(code_m));
    t = 0;
    m = 0;
    while (status.switch_pending === 1'b1 && m < 5000)
    begin
      t += int'(cpu_tick === 1'b1);
      m++;
      cyc(1);
    end
    if (c > 4 || mode_m == 0)
      check(t, c > 4 ? 0 : 32 >> old);
    rate();
  endtask

  initial
  begin
    rst_n = 1'b0;
    ccr_wr = 1'b0;
    osc_wr = 1'b0;
    wr_data = 8'h00;
    stop_req = 1'b0;
    halt_req = 1'b0;
    wake = 1'b0;
    code_m = 4;
    mode_m = 0;
    cyc(8);
    check({ccr_rb, osc_rb}, 32'h0000_0400);
    check({fxx_en, cpu_tick, status.osc_run}, 32'h0000_0000);
    rst_n = 1'b1;
    wait_run(n);
    check(n, STAB + 1);
    // scaler phase is free, so the first tick comes within one slow period
    next_tick(n);
    check(n <= (2 << 4), 1);
    rate();
    // every old code from slowest to fastest, then back
    for (int c = 3; c >= 0; c--)
      set_code(c);
    set_code(4);
    for (int c = 5; c < 8; c++)
      set_code(c);
    // peripheral ticks counted in main clock pulses
    for (int i = 0; i < 3; i++)
    begin
      k = 0;
      while (periph_tick[i] !== 1'b1 && k < 100)
      begin
        cyc(1);
        k++;
      end
      n = 0;
      do
      begin
        cyc(1);
        n += int'(fxx_en === 1'b1);
      end
      while (periph_tick[i] !== 1'b1 && n < 100);
      check(n, 2 << i);
    end
    // bypass the halving scaler
    osc_wr = 1'b1;
    wr_data = 8'h01;
    cyc(1);
    osc_wr = 1'b0;
    mode_m = 1;
    check(osc_rb, 32'h0000_0001);
    n = int'(fxx_en === 1'b1);
    cyc(1);
    n += int'(fxx_en === 1'b1);
    check(n, 0);
    n = 0;
    repeat (8)
    begin
      cyc(1);
      n += int'(fxx_en === 1'b1);
    end
    check(n, 8);
    rate();
    set_code(0);
    set_code(2);
    // halt stops only the cpu clock
    halt_req = 1'b1;
    cyc(1);
    halt_req = 1'b0;
    n = 0;
    k = 0;
    repeat (20)
    begin
      cyc(1);
      n += int'(cpu_tick === 1'b1);
      k += int'(fxx_en === 1'b1);
    end
    check({status.halted, 8'(n), 8'(k)}, 32'h0001_0014);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    rate();
    // stop silences every clock until wake and a new settling wait
    stop_req = 1'b1;
    cyc(1);
    stop_req = 1'b0;
    n = 0;
    repeat (20)
    begin
      cyc(1);
      n += int'(fxx_en !== 1'b0 || periph_tick !== '0 || cpu_tick !== 1'b0);
    end
    check({status.stopped, status.osc_run, 8'(n)}, 32'h0000_0200);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    next_tick(n);
    check(n > STAB, 1);
    // reset in mid-run restores the defaults
    rst_n = 1'b0;
    cyc(2);
    check({ccr_rb, osc_rb}, 32'h0000_0400);
    rst_n = 1'b1;
    code_m = 4;
    mode_m = 0;
    wait_run(n);
    check(n, STAB + 1);
    next_tick(n);
    check(n <= (2 << 4), 1);
    rate();
    wrap_up();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #(20 * 50_000);
    mismatches++;
    wrap_up();
  end
endmodule
